// ### logic/adc_power_temp_config_regs.sv
// configuration registers for low-rate select, temperature sensor and
// power modes of a quad-channel converter.
// assumes an apb master on pclk; shutdown pin and status lines are
// asynchronous and are synchronised here.
`timescale 1ns/10ps

// Summary of operation
// - conversion runs only while thermal control bit 6 is one.
// - temperature sensor enabled only while thermal control bit 5 is one.
// - bit 2 puts the 9-bit temperature on the read bits.
// - power bits 7..4 power down channels a..d individually.
// - power bit 3 places channels in standby.
// - power bit 2 forces global power-down.
// - bit 0 chooses whether a high pin means power-down or standby.
// - low-rate select sits in bits 1-0 of register 13h.
// - two temperature lsbs at 11h bits 5:4, rest at 10h.
// - temperature readout is two's complement.
module adc_power_temp_config_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 shutdown_pin,
  input  wire logic [3:0]           ref_status,
  input  wire logic                 clk_missing,
  input  wire logic                 sample_valid,
  input  wire logic [8:0]           sample_code,
  output logic                      sensor_en,
  output logic                      thermal_convert_en,
  output logic [1:0]                low_rate_sel,
  output logic                      ref_check_en,
  output logic                      dc_force_en,
  output logic                      stats_en,
  output adc_cfg_pkg::power_state_t power_state
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  adc_cfg_pkg::low_rate_t     low_rate;
  adc_cfg_pkg::thermal_ctrl_t therm_ctrl;
  adc_cfg_pkg::power_ctrl_t   power_ctrl;
  adc_cfg_pkg::apb_state_t    state;
  adc_cfg_pkg::apb_state_t    next_state;
  adc_cfg_pkg::power_state_t  next_power;
  logic [8:0]                 thermal_value;
  logic                       pin_sync;
  logic [3:0]                 ref_sync;
  logic                       clk_miss_sync;
  logic                       setup;
  logic                       wr_stb;
  logic                       mapped;
  logic [7:0]                 next_rdata;
  logic [7:0]                 hi_therm;
  logic [7:0]                 hi_status;
  logic [7:0]                 lo_byte;
  logic [7:0]                 wbyte;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [5:0] idx);
    hit = (a[ADDR_W-1:adc_cfg_pkg::ADDR_LSB] ==
           (ADDR_W-adc_cfg_pkg::ADDR_LSB)'(idx)) &&
          (a[adc_cfg_pkg::ADDR_LSB-1:0] == '0);
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  bit_sync #(
    .WIDTH (6)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({shutdown_pin, clk_missing, ref_status}),
    .sync_out ({pin_sync, clk_miss_sync, ref_sync})
  );

  // ----------------------------------------------------------------
  // temperature capture
  // ----------------------------------------------------------------
  thermal_hold #(
    .WIDTH (adc_cfg_pkg::THERM_W)
  ) u_therm (
    .pclk          (pclk),
    .presetn       (presetn),
    .sensor_en     (therm_ctrl.sensor_en),
    .convert_en    (therm_ctrl.thermal_convert_en),
    .sample_valid  (sample_valid),
    .sample_code   (sample_code),
    .thermal_value (thermal_value)
  );

  // ----------------------------------------------------------------
  // apb sequencing
  // ----------------------------------------------------------------
  // one access cycle, no wait states
  assign setup  = psel && !penable;
  assign wr_stb = psel && penable && pready && pwrite;
  assign wbyte  = pwdata[7:0];

  always_comb begin
    next_state = state;
    case (state)
      adc_cfg_pkg::ST_IDLE: begin
        if (setup) begin
          next_state = adc_cfg_pkg::ST_ACCESS;
        end
      end
      adc_cfg_pkg::ST_ACCESS: begin
        next_state = adc_cfg_pkg::ST_IDLE;
      end
      default: begin
        next_state = adc_cfg_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= adc_cfg_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= (next_state == adc_cfg_pkg::ST_ACCESS);
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign mapped = hit(paddr, adc_cfg_pkg::IDX_THERMAL_HI)   ||
                  hit(paddr, adc_cfg_pkg::IDX_THERMAL_LO)   ||
                  hit(paddr, adc_cfg_pkg::IDX_LOW_RATE)     ||
                  hit(paddr, adc_cfg_pkg::IDX_THERMAL_CTRL) ||
                  hit(paddr, adc_cfg_pkg::IDX_POWER_CTRL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !mapped;
    end else if (pready) begin
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // must-write-zero bits are not stored and read back zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_rate <= adc_cfg_pkg::REG_RESET;
    end else if (wr_stb && hit(paddr, adc_cfg_pkg::IDX_LOW_RATE)) begin
      low_rate <= wbyte & adc_cfg_pkg::LOW_RATE_MASK;
    end
  end

  // sensor-before-convert order is left to software; no interlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      therm_ctrl <= adc_cfg_pkg::REG_RESET;
    end else if (wr_stb &&
                 hit(paddr, adc_cfg_pkg::IDX_THERMAL_CTRL)) begin
      therm_ctrl <= wbyte & adc_cfg_pkg::THERM_CTL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_ctrl <= adc_cfg_pkg::REG_RESET;
    end else if (wr_stb && hit(paddr, adc_cfg_pkg::IDX_POWER_CTRL)) begin
      power_ctrl <= wbyte & adc_cfg_pkg::POWER_WR_MASK;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // status byte when temperature readout is off
  always_comb begin
    hi_status = '0;
    if (low_rate.ref_check_en) begin
      hi_status[7] = ref_sync[1];
      hi_status[6] = ref_sync[3];
      hi_status[5] = ref_sync[0];
      hi_status[0] = ref_sync[2];
    end
    hi_status[adc_cfg_pkg::CLK_STAT_POS] = clk_miss_sync;
  end

  // upper seven temperature bits scattered around the clock flag
  always_comb begin
    hi_therm    = hi_status;
    hi_therm[5] = thermal_value[2];
    hi_therm[6] = thermal_value[3];
    hi_therm[7] = thermal_value[4];
    hi_therm[0] = thermal_value[5];
    hi_therm[3:1] = thermal_value[8:6];
  end

  always_comb begin
    lo_byte = '0;
    if (therm_ctrl.thermal_readout_en) begin
      lo_byte[adc_cfg_pkg::LO_FIELD_POS +: 2] = thermal_value[1:0];
    end
  end

  always_comb begin
    next_rdata = '0;
    if (hit(paddr, adc_cfg_pkg::IDX_THERMAL_HI)) begin
      next_rdata = therm_ctrl.thermal_readout_en ? hi_therm : hi_status;
    end else if (hit(paddr, adc_cfg_pkg::IDX_THERMAL_LO)) begin
      next_rdata = lo_byte;
    end else if (hit(paddr, adc_cfg_pkg::IDX_LOW_RATE)) begin
      next_rdata = low_rate;
    end else if (hit(paddr, adc_cfg_pkg::IDX_THERMAL_CTRL)) begin
      next_rdata = therm_ctrl;
    end else if (hit(paddr, adc_cfg_pkg::IDX_POWER_CTRL)) begin
      // channel a and d bits are write-only
      next_rdata = power_ctrl & adc_cfg_pkg::POWER_RD_MASK;
    end
  end

  // sampled in setup so it is steady through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      prdata <= {24'h000000, next_rdata};
    end
  end

  // ----------------------------------------------------------------
  // power outputs
  // ----------------------------------------------------------------
  always_comb begin
    next_power.chan_off = {power_ctrl.chan_a_off,
                           power_ctrl.chan_b_off,
                           power_ctrl.chan_c_off,
                           power_ctrl.chan_d_off};
    next_power.standby = power_ctrl.standby ||
                         (pin_sync && power_ctrl.shutdown_pin_role);
    next_power.full_shutdown = power_ctrl.full_shutdown ||
                         (pin_sync && !power_ctrl.shutdown_pin_role);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_state <= '0;
    end else begin
      power_state <= next_power;
    end
  end

  // ----------------------------------------------------------------
  // sensor and serializer outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sensor_en          <= 1'b0;
      thermal_convert_en <= 1'b0;
    end else begin
      sensor_en          <= therm_ctrl.sensor_en;
      thermal_convert_en <= therm_ctrl.thermal_convert_en;
    end
  end

  // value choice by sample rate is software's job; no range check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_rate_sel <= '0;
      ref_check_en <= 1'b0;
      dc_force_en  <= 1'b0;
      stats_en     <= 1'b0;
    end else begin
      low_rate_sel <= low_rate.low_rate_sel;
      ref_check_en <= low_rate.ref_check_en;
      dc_force_en  <= low_rate.dc_force_en;
      stats_en     <= low_rate.stats_en;
    end
  end

endmodule

// ### logic/adc_cfg_pkg.sv
// register map, field layouts and carriers for the converter
// configuration bank.
// assumes an apb master with 32-bit data and one word per register.
package adc_cfg_pkg;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_THERMAL_HI   = 6'h10;
  localparam logic [5:0] IDX_THERMAL_LO   = 6'h11;
  localparam logic [5:0] IDX_LOW_RATE     = 6'h13;
  localparam logic [5:0] IDX_THERMAL_CTRL = 6'h14;
  localparam logic [5:0] IDX_POWER_CTRL   = 6'h15;
  localparam int         ADDR_LSB         = 2;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         THERM_W        = 9;
  localparam int         LO_FIELD_POS   = 4;
  localparam int         CLK_STAT_POS   = 4;
  localparam logic [7:0] LOW_RATE_MASK  = 8'h73;
  localparam logic [7:0] THERM_CTL_MASK = 8'h64;
  localparam logic [7:0] POWER_WR_MASK  = 8'hfd;
  localparam logic [7:0] POWER_RD_MASK  = 8'h6d;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [1:0] LOW_RATE_FAST1 = 2'h2;
  localparam logic [1:0] LOW_RATE_FAST2 = 2'h3;
  localparam int         SYNC_STAGES    = 2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       rsvd7;
    logic       ref_check_en;
    logic       dc_force_en;
    logic       stats_en;
    logic [1:0] rsvd3_2;
    logic [1:0] low_rate_sel;
  } low_rate_t;

  typedef struct packed {
    logic       rsvd7;
    logic       thermal_convert_en;
    logic       sensor_en;
    logic [1:0] rsvd4_3;
    logic       thermal_readout_en;
    logic [1:0] rsvd1_0;
  } thermal_ctrl_t;

  typedef struct packed {
    logic       chan_a_off;
    logic       chan_b_off;
    logic       chan_c_off;
    logic       chan_d_off;
    logic       standby;
    logic       full_shutdown;
    logic       rsvd1;
    logic       shutdown_pin_role;
  } power_ctrl_t;

  typedef struct packed {
    logic [3:0] chan_off;
    logic       standby;
    logic       full_shutdown;
  } power_state_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ACCESS = 2'b10
  } apb_state_t;

endpackage

// ### logic/bit_sync.sv
// two-flop synchroniser, one chain per bit.
// assumes inputs are static levels from outside the pclk domain.
`timescale 1ns/10ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // chains
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_chain
      logic meta;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta        <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta        <= async_in[i];
          sync_out[i] <= meta;
        end
      end
    end
  endgenerate

endmodule

// ### logic/thermal_hold.sv
// holds the last converted temperature word.
// assumes the sensor front end offers a two's complement code with a
// one-cycle valid on pclk.
`timescale 1ns/10ps
module thermal_hold #(
  parameter int WIDTH = 9
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             sensor_en,
  input  wire logic             convert_en,
  input  wire logic             sample_valid,
  input  wire logic [WIDTH-1:0] sample_code,
  output logic      [WIDTH-1:0] thermal_value
);

  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  // code passed through unchanged: already signed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thermal_value <= '0;
    end else if (sensor_en && convert_en && sample_valid) begin
      thermal_value <= sample_code;
    end
  end

endmodule

// ### verification/adc_cfg_monitor.sv
// concurrent checks on the configuration bank ports.
// assumes a single pclk domain and aligned apb byte addresses.
`timescale 1ns/10ps
module adc_cfg_monitor #(
  parameter int ADDR_W = 8
) (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [ADDR_W-1:0]        paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     shutdown_pin,
  input wire logic                     sensor_en,
  input wire logic                     thermal_convert_en,
  input wire logic [1:0]               low_rate_sel,
  input wire adc_cfg_pkg::power_state_t power_state
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic       wr_pwr;
  logic       wr_thr;
  logic       wr_low;
  logic       mapped;
  logic [7:0] last_pwr;
  logic [7:0] last_thr;
  logic [7:0] last_low;
  logic [1:0] quiet;
  assign wr_pwr = psel & penable & pready & pwrite & (paddr == 8'h54);
  assign wr_thr = psel & penable & pready & pwrite & (paddr == 8'h50);
  assign wr_low = psel & penable & pready & pwrite & (paddr == 8'h4c);
  assign mapped = paddr inside {8'h40, 8'h44, 8'h4c, 8'h50, 8'h54};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_pwr <= 8'h00;
      last_thr <= 8'h00;
      last_low <= 8'h00;
    end else begin
      if (wr_pwr) last_pwr <= pwdata[7:0];
      if (wr_thr) last_thr <= pwdata[7:0];
      if (wr_low) last_low <= pwdata[7:0];
    end
  end
  // cycles since the last power write, so outputs have settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet <= 2'h0;
    else if (wr_pwr) quiet <= 2'h0;
    else if (quiet != 2'h3) quiet <= quiet + 2'h1;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  // prdata only reloads on a read setup, so a refused write leaves it
  a_err_unmapped: assert property (pready && !mapped |-> pslverr
    && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_no_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_thermal_write: assert property (wr_thr |-> ##[1:3]
    (sensor_en == last_thr[5] && thermal_convert_en == last_thr[6]))
    else $error("thermal enables do not follow write");
  a_thermal_stable: assert property (!$stable({sensor_en, thermal_convert_en})
    |-> $past(wr_thr) || $past(wr_thr, 2) || $past(wr_thr, 3))
    else $error("thermal enables changed without write");
  a_low_rate_write: assert property (wr_low |-> ##[1:3]
    low_rate_sel == last_low[1:0])
    else $error("low rate select does not follow write");
  a_chan_write: assert property (wr_pwr |-> ##[1:3]
    power_state.chan_off == last_pwr[7:4])
    else $error("channel power-down does not follow write");
  a_pin_low_modes: assert property ((!shutdown_pin)[*4] ##0 quiet == 2'h3
    |-> power_state.standby == last_pwr[3]
    && power_state.full_shutdown == last_pwr[2])
    else $error("power modes wrong with pin low");
  a_pin_high_modes: assert property (shutdown_pin[*4] ##0 quiet == 2'h3
    |-> power_state.standby == (last_pwr[3] | last_pwr[0])
    && power_state.full_shutdown == (last_pwr[2] | !last_pwr[0]))
    else $error("power modes wrong with pin high");
endmodule

bind adc_power_temp_config_regs adc_cfg_monitor #(.ADDR_W(ADDR_W)) mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .shutdown_pin(shutdown_pin),
  .sensor_en(sensor_en), .thermal_convert_en(thermal_convert_en),
  .low_rate_sel(low_rate_sel), .power_state(power_state));

// ### verification/testbench.sv
// self-checking bench for the configuration bank, apb master inside.
// assumes one access cycle per transfer, no partner model.
`timescale 1ns/10ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, shutdown_pin;
  logic clk_missing, sample_valid, pready, pslverr, sensor_en;
  logic thermal_convert_en, ref_check_en, dc_force_en, stats_en;
  logic [7:0]  paddr, sh_low, sh_thr, sh_pwr, d;
  logic [31:0] pwdata, prdata;
  logic [3:0]  ref_status;
  logic [8:0]  sample_code, code;
  logic [1:0]  low_rate_sel;
  adc_cfg_pkg::power_state_t power_state;
  int miscompares, n_compared, cycles;

  adc_power_temp_config_regs #(.ADDR_W(8)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shutdown_pin(shutdown_pin),
    .ref_status(ref_status), .clk_missing(clk_missing),
    .sample_valid(sample_valid), .sample_code(sample_code),
    .sensor_en(sensor_en), .thermal_convert_en(thermal_convert_en),
    .low_rate_sel(low_rate_sel), .ref_check_en(ref_check_en),
    .dc_force_en(dc_force_en), .stats_en(stats_en),
    .power_state(power_state));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_of_test;
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] hi_exp(logic [8:0] v, logic cm);
    return {v[4], v[3], v[2], cm, v[8:6], v[5]};
  endfunction
  // one edge passes first so psel is never assigned twice in a step
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] wd, input logic [31:0] eq,
                      input logic ee);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w;
    paddr <= a; pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1);
    check("access_cycles", 32'(n), 32'd1);
    check("pslverr", pslverr, ee);
    if (!w) check("prdata", prdata, eq);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic outs;
    repeat (5) @(posedge pclk);
    check("low_rate_sel", low_rate_sel, sh_low[1:0]);
    check("diag_en", {ref_check_en, dc_force_en, stats_en}, sh_low[6:4]);
    check("sensor_en", sensor_en, sh_thr[5]);
    check("convert_en", thermal_convert_en, sh_thr[6]);
    check("chan_off", power_state.chan_off, sh_pwr[7:4]);
    check("standby", power_state.standby,
          sh_pwr[3] | (shutdown_pin & sh_pwr[0]));
    check("full_shutdown", power_state.full_shutdown,
          sh_pwr[2] | (shutdown_pin & ~sh_pwr[0]));
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    xfer(1'b1, a, v, 32'h0, 1'b0);
    if (a == 8'h4c) sh_low = v & adc_cfg_pkg::LOW_RATE_MASK;
    if (a == 8'h50) sh_thr = v & adc_cfg_pkg::THERM_CTL_MASK;
    if (a == 8'h54) sh_pwr = v & adc_cfg_pkg::POWER_WR_MASK;
    outs();
  endtask
  task automatic readall;
    xfer(1'b0, 8'h4c, 8'h0, {24'h0, sh_low}, 1'b0);
    xfer(1'b0, 8'h50, 8'h0, {24'h0, sh_thr}, 1'b0);
    xfer(1'b0, 8'h54, 8'h0, {24'h0, sh_pwr & 8'h6d}, 1'b0);
  endtask
  task automatic sample(input logic [8:0] v);
    sample_code <= v; sample_valid <= 1'b1;
    @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // clock, timeout, sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, shutdown_pin} = 5'h0;
    {clk_missing, sample_valid, paddr, pwdata} = 42'h0;
    {ref_status, sample_code, sh_low, sh_thr, sh_pwr} = 37'h0;
    {miscompares, n_compared, cycles} = 96'h0;
    void'($urandom(72));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    readall();
    outs();
    for (int i = 0; i < 4; i++) wreg(8'h4c, 8'(i));
    for (int i = 0; i < 24; i++) begin
      d = 8'($urandom);
      wreg(8'h4c + 8'(4 * (i % 3)), d);
      readall();
    end
    for (int k = 0; k < 8; k++) begin
      shutdown_pin <= k[0];
      wreg(8'h54, {4'($urandom), k[2], 2'b00, k[1]});
    end
    shutdown_pin <= 1'b0;
    xfer(1'b1, 8'h48, 8'hff, 32'h0, 1'b1);
    xfer(1'b0, 8'h5c, 8'h00, 32'h0, 1'b1);
    wreg(8'h4c, 8'h00);
    wreg(8'h50, 8'h20);
    wreg(8'h50, 8'h64);
    for (int i = 0; i < 6; i++) begin
      code = (i == 0) ? 9'h100 : (i == 1) ? 9'h0ff : 9'($urandom);
      clk_missing <= i[0];
      sample(code);
      xfer(1'b0, 8'h44, 8'h0, {26'h0, code[1:0], 4'h0}, 1'b0);
      xfer(1'b0, 8'h40, 8'h0, {24'h0, hi_exp(code, i[0])}, 1'b0);
    end
    xfer(1'b1, 8'h40, 8'hff, 32'h0, 1'b0);
    wreg(8'h50, 8'h24);
    sample(~code);
    xfer(1'b0, 8'h44, 8'h0, {26'h0, code[1:0], 4'h0}, 1'b0);
    xfer(1'b0, 8'h40, 8'h0, {24'h0, hi_exp(code, 1'b1)}, 1'b0);
    wreg(8'h50, 8'h60);
    xfer(1'b0, 8'h44, 8'h0, 32'h0, 1'b0);
    ref_status <= 4'($urandom);
    wreg(8'h4c, 8'h40);
    xfer(1'b0, 8'h40, 8'h0, {24'h0, ref_status[1], ref_status[3],
         ref_status[0], 1'b1, 3'b000, ref_status[2]}, 1'b0);
    wreg(8'h54, 8'hfd);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    {sh_low, sh_thr, sh_pwr} = 24'h0;
    readall();
    outs();
    end_of_test();
  end
endmodule
